// ---- hw/code_mapper.sv ----
`timescale 1ns/1ps
// turns a requested value into the word the converter switches expect
module code_mapper #(
  parameter int W = 12
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic [W-1:0]                value_in,
  input  wire dac_host_pkg::code_mode_type mode_in,
  output logic      [W-1:0]                code_out
);
  if (W != dac_host_pkg::DATA_W)
  begin : g_bad_width
    $error("code_mapper width must match converter");
  end

  logic [W-1:0] code_nxt;
  // two's complement becomes offset binary by flipping the msb only
  assign code_nxt = (mode_in == dac_host_pkg::MODE_TWOS) ? (value_in ^ dac_host_pkg::MSB_MASK)
                                                          : value_in;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      code_out <= dac_host_pkg::DATA_RST;
    else
      code_out <= code_nxt;
  end
endmodule // code_mapper

// ---- hw/dac_host_pkg.sv ----
package dac_host_pkg;
  localparam int          DATA_W        = 12;
  localparam int          HALF_SCALE    = 2048;
  localparam int          FULL_SCALE    = 4096;
  localparam logic [11:0] MSB_MASK      = 12'h800;
  localparam logic [11:0] CODE_ZERO_OB  = 12'h800;
  localparam logic [11:0] DATA_RST      = 12'h000;
  localparam int          LOW_BYTE_W    = 8;
  localparam int          HIGH_NIB_W    = 4;
  // pin timing, ns
  localparam int          T_CS_SETUP_NS = 210;
  localparam int          T_WR_PULSE_NS = 210;
  localparam int          T_DS_NS       = 300;
  localparam int          T_DH_NS       = 10;
  localparam int          CLK_NS        = 4;
  localparam int          CS_SETUP_CYC  = (T_CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          WR_PULSE_CYC  = (T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          DS_CYC        = (T_DS_NS + CLK_NS - 1) / CLK_NS;
  localparam int          DH_CYC        = (T_DH_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W         = 8;
  // code modes
  typedef enum logic [1:0] {
    MODE_UNIPOLAR = 2'h0,
    MODE_TWOS     = 2'h1,
    MODE_OFFSET   = 2'h2
  } code_mode_type;
  // wiring schemes
  typedef enum logic [1:0] {
    SCHEME_WIDE  = 2'h0,
    SCHEME_SPLIT = 2'h1,
    SCHEME_ADDR  = 2'h2
  } scheme_type;
  localparam int          ADDR_W        = 16;
  localparam int          SEL_W         = 4;
endpackage

// ---- hw/dac_write_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dac_write_host #(
  parameter dac_host_pkg::scheme_type SCHEME = dac_host_pkg::SCHEME_WIDE,
  parameter logic [3:0]                DAC_SEL = 4'h1
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        req_valid_in,
  input  wire logic [11:0]                 req_value_in,
  input  wire dac_host_pkg::code_mode_type req_mode_in,
  output logic                             req_ready_out,
  output logic                             done_out,
  output logic [11:0]                      dac_data_out,
  output logic                             dac_wr_n_out,
  output logic                             dac_cs_n_out,
  output logic [15:0]                      bus_addr_out,
  output logic [7:0]                       bus_data_out,
  output logic                             nib_latch_we_out
);
  localparam int CW       = dac_host_pkg::CNT_W;
  // mapper output is one flop behind value_r
  localparam int MAP_WAIT = 1;

  // elaboration checks: the longest count must fit the counter
  if (dac_host_pkg::DS_CYC + dac_host_pkg::DH_CYC >= (1 << CW))
  begin : g_cnt_too_narrow
    $error("counter too narrow");
  end
  if (dac_host_pkg::CS_SETUP_CYC < 1 || dac_host_pkg::DH_CYC < 1)
  begin : g_count_zero
    $error("timing counts must be at least one");
  end

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_MAP   = 7'h02,
    ST_NIB   = 7'h04,
    ST_SETUP = 7'h08,
    ST_PULSE = 7'h10,
    ST_HOLD  = 7'h20,
    ST_DONE  = 7'h40
  } state_type;

  ////////////////////////////////////////////////////////////////////////////
  state_type        state_r;
  state_type        state_nxt;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic [1:0]       mode_r;
  logic [11:0]      value_r;
  logic [11:0]      mapped;
  logic             cnt_zero;
  logic [CW-1:0]    setup_load;
  logic [CW-1:0]    pulse_load;
  logic [CW-1:0]    hold_load;
  logic [15:0]      addr_word;
  logic             ready_nxt;
  logic             done_nxt;
  logic             nib_we_nxt;
  logic             word_load;
  logic             cs_n_nxt;
  logic             wr_n_nxt;
  logic [15:0]      addr_nxt;
  logic [15:0]      nib_addr;
  logic [7:0]       nib_byte;

  code_mapper #(.W(12)) u_map (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .value_in (value_r),
    .mode_in  (dac_host_pkg::code_mode_type'(mode_r)),
    .code_out (mapped)
  );

  assign cnt_zero   = (cnt_r == '0);
  // select must lead the strobe; data must settle before the strobe rises
  assign setup_load = CW'(dac_host_pkg::CS_SETUP_CYC - 1);
  assign pulse_load = CW'((dac_host_pkg::WR_PULSE_CYC > dac_host_pkg::DS_CYC ?
                           dac_host_pkg::WR_PULSE_CYC : dac_host_pkg::DS_CYC) - 1);
  assign hold_load  = CW'(dac_host_pkg::DH_CYC - 1);
  // data lives in the low twelve address lines, selector in the top four
  assign addr_word  = {DAC_SEL, mapped};
  // the nibble goes to its own address, one above the word address
  assign nib_addr   = {DAC_SEL, 12'h001};
  assign nib_byte   = {4'h0, mapped[11:8]};
  assign addr_nxt   = (SCHEME == dac_host_pkg::SCHEME_ADDR) ? addr_word : {DAC_SEL, 12'h000};

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_zero ? cnt_r : cnt_r - CW'(1);
    unique case (state_r)
      ST_IDLE:
        if (req_valid_in)
        begin
          state_nxt = ST_MAP;
          cnt_nxt   = CW'(MAP_WAIT);
        end
      // wait until the mapper has registered the new value
      ST_MAP:
        if (cnt_zero)
        begin
          state_nxt = (SCHEME == dac_host_pkg::SCHEME_SPLIT) ? ST_NIB : ST_SETUP;
          cnt_nxt   = setup_load;
        end
      // nibble phase must not eat into the select lead time
      ST_NIB:
      begin
        state_nxt = ST_SETUP;
        cnt_nxt   = setup_load;
      end
      ST_SETUP:
        if (cnt_zero)
        begin
          state_nxt = ST_PULSE;
          cnt_nxt   = pulse_load;
        end
      ST_PULSE:
        if (cnt_zero)
        begin
          state_nxt = ST_HOLD;
          cnt_nxt   = hold_load;
        end
      ST_HOLD:
        if (cnt_zero)
          state_nxt = ST_DONE;
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      mode_r  <= 2'h0;
      value_r <= dac_host_pkg::DATA_RST;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (state_r == ST_IDLE && req_valid_in)
      begin
        value_r <= req_value_in;
        mode_r  <= req_mode_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins are registered so no decode glitch reaches the transparent latch
  assign ready_nxt  = (state_nxt == ST_IDLE);
  assign done_nxt   = (state_nxt == ST_DONE);
  assign nib_we_nxt = (state_nxt == ST_NIB);
  // data is driven on the same edge as select, before the strobe, held past strobe release
  assign word_load  = (state_nxt == ST_SETUP) && (state_r != ST_SETUP);
  assign cs_n_nxt   = !(state_nxt == ST_SETUP || state_nxt == ST_PULSE || state_nxt == ST_HOLD);
  // strobe low only inside the stable-data window
  assign wr_n_nxt   = !(state_nxt == ST_PULSE);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_ready_out    <= 1'b0;
      done_out         <= 1'b0;
      nib_latch_we_out <= 1'b0;
    end
    else
    begin
      req_ready_out    <= ready_nxt;
      done_out         <= done_nxt;
      nib_latch_we_out <= nib_we_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dac_wr_n_out <= 1'b1;
      dac_cs_n_out <= 1'b1;
    end
    else
    begin
      dac_wr_n_out <= wr_n_nxt;
      dac_cs_n_out <= cs_n_nxt;
    end
  end

  // word, address and low byte stand until the next write
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dac_data_out <= dac_host_pkg::DATA_RST;
      bus_addr_out <= 16'h0000;
      bus_data_out <= 8'h00;
    end
    else if (nib_we_nxt)
    begin
      bus_addr_out <= nib_addr;
      bus_data_out <= nib_byte;
    end
    else if (word_load)
    begin
      dac_data_out <= mapped;
      bus_addr_out <= addr_nxt;
      bus_data_out <= mapped[7:0];
    end
  end
endmodule // dac_write_host

// ---- test/dac_device_model.sv ----
`timescale 1ns/1ps
module dac_device_model (
  input  wire logic [11:0] data_in,
  input  wire logic        wr_n_in,
  input  wire logic        cs_n_in,
  output logic [11:0]      word_out
);
  // follows the pins while both strobes low, keeps last word after
  always_latch
    if (!wr_n_in && !cs_n_in) word_out <= data_in;
endmodule // dac_device_model

// ---- test/dac_write_host_asserts.sv ----
`timescale 1ns/1ps
module dac_write_host_asserts #(
  parameter dac_host_pkg::scheme_type SCHEME  = dac_host_pkg::SCHEME_WIDE,
  parameter logic [3:0]               DAC_SEL = 4'h1
) (
  input wire logic                        clk_in,
  input wire logic                        rst_in,
  input wire logic                        req_valid_in,
  input wire logic [11:0]                 req_value_in,
  input wire dac_host_pkg::code_mode_type req_mode_in,
  input wire logic                        req_ready_out,
  input wire logic                        done_out,
  input wire logic [11:0]                 dac_data_out,
  input wire logic                        dac_wr_n_out,
  input wire logic                        dac_cs_n_out,
  input wire logic [15:0]                 bus_addr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // split scheme spends one more cycle on the nibble before driving the word
  localparam int MAP_LAT    = (SCHEME == dac_host_pkg::SCHEME_SPLIT) ? 4 : 3;
  localparam int CS_LEAD    = dac_host_pkg::CS_SETUP_CYC - 1;
  localparam int PULSE_LEN  = (dac_host_pkg::WR_PULSE_CYC > dac_host_pkg::DS_CYC) ?
                              dac_host_pkg::WR_PULSE_CYC : dac_host_pkg::DS_CYC;
  localparam int PULSE_LAST = PULSE_LEN - 1;
  sequence s_take; req_valid_in && req_ready_out; endsequence
  sequence s_hold; !dac_cs_n_out [*3] ##1 dac_cs_n_out; endsequence
  sequence s_wr_fall; $fell(dac_wr_n_out); endsequence
  AST_MAP: assert property (s_take |-> ##MAP_LAT dac_data_out == ($past(req_value_in, MAP_LAT) ^
    (($past(req_mode_in, MAP_LAT) == dac_host_pkg::MODE_TWOS) ? dac_host_pkg::MSB_MASK : 12'h000)))
    else $error("bad code");
  AST_CS_LEAD: assert property ($fell(dac_cs_n_out) |-> ##CS_LEAD dac_wr_n_out ##1 !dac_wr_n_out)
    else $error("select lead wrong");
  AST_PULSE_LEN: assert property (s_wr_fall |-> ##PULSE_LAST !dac_wr_n_out ##1 dac_wr_n_out)
    else $error("strobe length wrong");
  AST_HOLD: assert property ($rose(dac_wr_n_out) |-> s_hold)
    else $error("select hold wrong");
  AST_SEL: assert property (!dac_cs_n_out |-> bus_addr_out[15:12] == DAC_SEL)
    else $error("bad select");
  AST_ADDR: assert property (SCHEME == dac_host_pkg::SCHEME_ADDR && !dac_cs_n_out |->
    bus_addr_out[11:0] == dac_data_out) else $error("bad address data");
  AST_STABLE: assert property (!dac_wr_n_out |-> $stable(dac_data_out)) else $error("data moved");
  AST_SETUP: assert property ($fell(dac_cs_n_out) |-> ##[1:80] !dac_wr_n_out) else $error("no write");
  AST_PULSE: assert property (s_wr_fall |-> (!dac_wr_n_out && !dac_cs_n_out) [*8])
    else $error("short strobe");
  AST_DONE: assert property (done_out |-> dac_cs_n_out && dac_wr_n_out ##1 !done_out)
    else $error("bad done");
endmodule // dac_write_host_asserts
bind dac_write_host dac_write_host_asserts #(.SCHEME(SCHEME), .DAC_SEL(DAC_SEL)) u_asserts (.clk_in(clk_in),
  .rst_in(rst_in), .req_valid_in(req_valid_in), .req_value_in(req_value_in), .req_mode_in(req_mode_in),
  .req_ready_out(req_ready_out), .done_out(done_out), .dac_data_out(dac_data_out), .dac_wr_n_out(dac_wr_n_out),
  .dac_cs_n_out(dac_cs_n_out), .bus_addr_out(bus_addr_out));

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        req_valid_in = 1'b0;
  logic [11:0] req_value_in = 12'h000;
  dac_host_pkg::code_mode_type req_mode_in = dac_host_pkg::MODE_UNIPOLAR;
  logic        req_ready_out, done_out, dac_wr_n_out, dac_cs_n_out;
  logic [11:0] dac_data_out, word;
  logic [15:0] bus_addr_out;
  logic        split_ready, split_done, split_wr_n, split_cs_n, split_we;
  logic [7:0]  split_byte;
  logic [15:0] split_addr, nib_addr_r;
  logic [11:0] split_word;
  logic [3:0]  nib_r;
  int          fail_count = 0;
  int          num_checks = 0;
  always #2 clk_in = ~clk_in;
  dac_write_host #(.SCHEME(dac_host_pkg::SCHEME_ADDR), .DAC_SEL(4'h5)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_value_in(req_value_in), .req_mode_in(req_mode_in),
    .req_ready_out(req_ready_out), .done_out(done_out), .dac_data_out(dac_data_out), .dac_wr_n_out(dac_wr_n_out),
    .dac_cs_n_out(dac_cs_n_out), .bus_addr_out(bus_addr_out), .bus_data_out(), .nib_latch_we_out());
  dac_device_model u_dev (.data_in(dac_data_out), .wr_n_in(dac_wr_n_out), .cs_n_in(dac_cs_n_out), .word_out(word));
  dac_write_host #(.SCHEME(dac_host_pkg::SCHEME_SPLIT), .DAC_SEL(4'h3)) dut_split (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_value_in(req_value_in), .req_mode_in(req_mode_in),
    .req_ready_out(split_ready), .done_out(split_done), .dac_data_out(), .dac_wr_n_out(split_wr_n),
    .dac_cs_n_out(split_cs_n), .bus_addr_out(split_addr), .bus_data_out(split_byte), .nib_latch_we_out(split_we));
  // host-side nibble holding latch of the two-address scheme
  always @(posedge clk_in)
    if (split_we)
    begin
      nib_r      <= split_byte[3:0];
      nib_addr_r <= split_addr;
    end
  dac_device_model u_dev_split (.data_in({nib_r, split_byte}), .wr_n_in(split_wr_n), .cs_n_in(split_cs_n),
    .word_out(split_word));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic launch(input logic [11:0] v, input dac_host_pkg::code_mode_type m);
    do @(negedge clk_in); while (req_ready_out !== 1'b1 || split_ready !== 1'b1);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_value_in <= v;
    req_mode_in <= m;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
  endtask
  task automatic finish_write();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 400)
    begin
      @(negedge clk_in);
      n++;
    end
    check({15'h0, done_out}, 16'h0001);
    while (split_done !== 1'b1 && n < 400)
    begin
      @(negedge clk_in);
      n++;
    end
    check({15'h0, split_done}, 16'h0001);
  endtask
  task automatic write_check(input logic [11:0] v, input dac_host_pkg::code_mode_type m);
    logic [11:0] exp;
    exp = (m == dac_host_pkg::MODE_TWOS) ? v ^ 12'h800 : v;
    launch(v, m);
    finish_write();
    check({4'h0, word}, {4'h0, exp});
    check(bus_addr_out, {4'h5, exp});
    check({4'h0, split_word}, {4'h0, exp});
    check({8'h00, split_byte}, {8'h00, exp[7:0]});
    check({12'h000, nib_r}, {12'h000, exp[11:8]});
    check(split_addr, {4'h3, 12'h000});
    check({15'h0, nib_addr_r == split_addr}, 16'h0000);
  endtask
  task automatic test_unipolar();
    write_check(12'h000, dac_host_pkg::MODE_UNIPOLAR);
    write_check(12'h800, dac_host_pkg::MODE_UNIPOLAR);
    write_check(12'hfff, dac_host_pkg::MODE_UNIPOLAR);
  endtask
  task automatic test_twos();
    write_check(12'h7ff, dac_host_pkg::MODE_TWOS);
    write_check(12'h800, dac_host_pkg::MODE_TWOS);
    write_check(12'hfff, dac_host_pkg::MODE_TWOS);
    check({15'h0, word[11]}, 16'h0000);
  endtask
  task automatic test_offset();
    write_check(12'h800, dac_host_pkg::MODE_OFFSET);
    write_check(12'h000, dac_host_pkg::MODE_OFFSET);
  endtask
  task automatic test_refused_hold();
    launch(12'h123, dac_host_pkg::MODE_OFFSET);
    repeat (10) @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_value_in <= 12'h456;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    finish_write();
    repeat (200) @(negedge clk_in);
    check({4'h0, word}, 16'h0123);
    check({4'h0, split_word}, 16'h0123);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    test_unipolar();
    test_twos();
    test_offset();
    test_refused_hold();
    summarize();
  end
  // nine writes of about 140 cycles each; over tenfold margin
  initial
  begin
    #80000;
    fail_count++;
    summarize();
  end
endmodule // tb_top
